// ### hw/pg_pin_cell.sv
// one port g pin: read-back choice and generic output drive
// assumes the function owner drives the pin itself whenever func_active is high
`timescale 1ns/1ps

module pg_pin_cell (
  input  wire logic               dir,
  input  wire logic               func_active,
  input  wire logic               data_q,
  input  wire logic               pin_in,
  output      logic               read_bit,
  output      pinmux_pkg::pin_drive_s drive
);

  // ==========================================================================
  // read-back
  always_comb begin
    if (!dir) begin
      read_bit = pin_in;
    end else begin
      read_bit = data_q;
    end
  end

  // ==========================================================================
  // generic output drive
  always_comb begin
    drive.out = data_q;
    drive.oe  = dir && !func_active;
  end

endmodule

// ### hw/pinmux_pkg.sv
// constants, field layouts and carrier types for the port f / port g pin function block
// assumes a 16-bit register port whose address carries the low byte of each register offset
package pinmux_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================================
  // register offsets (low byte of the address)
  localparam logic [ADDR_W-1:0] OFS_PF_LOW_SEL   = 8'hAC;
  localparam logic [ADDR_W-1:0] OFS_PG_DATA      = 8'hAE;
  localparam logic [ADDR_W-1:0] OFS_PG_DIR       = 8'hB0;
  localparam logic [ADDR_W-1:0] OFS_PF_ROLE_STAT = 8'hB6;

  // ==========================================================================
  // port f function select field positions
  localparam int PF7_FUNC_LSB = 14;
  localparam int PF6_FUNC_LSB = 12;
  localparam int PF5_FUNC_LSB = 10;
  localparam int PF4_FUNC_LSB = 8;
  localparam int PF3_FUNC_BIT = 6;
  localparam int PF2_FUNC_BIT = 4;
  localparam int PF1_FUNC_BIT = 2;
  localparam int PF0_FUNC_BIT = 0;
  // single-bit selects sit every second bit from bit 0
  localparam int PF_SINGLE_STRIDE = 2;

  // ==========================================================================
  // reset values and write masks
  localparam logic [DATA_W-1:0] PF_LOW_SEL_RESET = 16'h00AA;
  localparam logic [DATA_W-1:0] PF_LOW_SEL_WMASK = 16'hFF55;
  localparam logic [DATA_W-1:0] PG_DATA_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0] PG_DIR_RESET     = 16'h0000;
  localparam logic [DATA_W-1:0] RD_UNMAPPED      = 16'h0000;

  // ==========================================================================
  // two-bit function codes
  localparam logic [1:0] FUNC_GPIO  = 2'h0;
  localparam logic [1:0] FUNC_ALT   = 2'h1;
  localparam logic [1:0] FUNC_PULSE = 2'h2;
  localparam logic [1:0] FUNC_RSVD  = 2'h3;

  typedef enum logic [2:0] {
    PIN_GPIO,
    PIN_DMA_REQ,
    PIN_DMA_ACK,
    PIN_PULSE,
    PIN_IRQ
  } pin_role_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage

// ### hw/port_pin_function_select.sv
// pin function selection for port f pins 7..0 and the port g data register
// assumes port f generic data/direction logic, port g function control and the
// dma, interrupt and pulse units sit outside and meet this block at plain ports
`timescale 1ns/1ps


module port_pin_function_select #(
  parameter int         PF_PINS     = 8,
  parameter int         PG_PINS     = 16,
  parameter logic       PERIPH_IDLE = 1'b1
) (
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire pinmux_pkg::reg_req_s       reg_req,
  output      logic [pinmux_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       expanded_mode,
  input  wire logic [PF_PINS-1:0]         pf_pin_in,
  output      logic [PF_PINS-1:0]         pf_pin_out,
  output      logic [PF_PINS-1:0]         pf_pin_oe,
  input  wire logic [PF_PINS-1:0]         pf_gpio_out,
  input  wire logic [PF_PINS-1:0]         pf_gpio_oe,
  output      logic [PF_PINS-1:0]         pf_gpio_in,
  output      logic [PF_PINS-1:0]         pf_pin_is_gpio,
  output      logic [1:0]                 dma_request,
  input  wire logic [1:0]                 dma_acknowledge,
  input  wire logic [3:0]                 pulse_out,
  output      logic [3:0]                 ext_interrupt_request,
  input  wire logic [PG_PINS-1:0]         pg_pin_in,
  output      logic [PG_PINS-1:0]         pg_pin_out,
  output      logic [PG_PINS-1:0]         pg_pin_oe,
  input  wire logic [PG_PINS-1:0]         pg_func_active,
  output      logic [PG_PINS-1:0]         port_g_direction
);

  // ==========================================================================
  // register storage
  logic [pinmux_pkg::DATA_W-1:0] pf_sel_reg;
  logic [PG_PINS-1:0]            pg_data_reg;
  logic [PG_PINS-1:0]            pg_dir_reg;
  logic [pinmux_pkg::DATA_W-1:0] rdata_reg;
  logic [pinmux_pkg::DATA_W-1:0] rdata_next;

  logic wr_pf_sel;
  logic wr_pg_data;
  logic wr_pg_dir;

  assign wr_pf_sel  = reg_req.wr && (reg_req.addr == pinmux_pkg::OFS_PF_LOW_SEL);
  assign wr_pg_data = reg_req.wr && (reg_req.addr == pinmux_pkg::OFS_PG_DATA);
  assign wr_pg_dir  = reg_req.wr && (reg_req.addr == pinmux_pkg::OFS_PG_DIR);

  // ==========================================================================
  // port f function select register
  // reserved odd bits of the low byte are read-only ones; the mask keeps them
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pf_sel_reg <= pinmux_pkg::PF_LOW_SEL_RESET;
    end else if (wr_pf_sel) begin
      pf_sel_reg <= (reg_req.wdata & pinmux_pkg::PF_LOW_SEL_WMASK)
                  | (pinmux_pkg::PF_LOW_SEL_RESET & ~pinmux_pkg::PF_LOW_SEL_WMASK);
    end
  end

  // ==========================================================================
  // port g data register
  // a write always lands in storage; whether it reaches the pin is the cell's call
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pg_data_reg <= pinmux_pkg::PG_DATA_RESET;
    end else if (wr_pg_data) begin
      pg_data_reg <= reg_req.wdata[PG_PINS-1:0];
    end
  end

  // ==========================================================================
  // port g direction register
  // a cleared bit releases the pad one cycle later, through the pg_pin_oe flop behind the cell
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pg_dir_reg <= pinmux_pkg::PG_DIR_RESET;
    end else if (wr_pg_dir) begin
      pg_dir_reg <= reg_req.wdata[PG_PINS-1:0];
    end
  end

  assign port_g_direction = pg_dir_reg;

  // ==========================================================================
  // port f role decode
  pinmux_pkg::pin_role_e pf_role [PF_PINS];

  logic [1:0] pf7_code;
  logic [1:0] pf6_code;
  logic [1:0] pf5_code;
  logic [1:0] pf4_code;

  assign pf7_code = pf_sel_reg[pinmux_pkg::PF7_FUNC_LSB +: 2];
  assign pf6_code = pf_sel_reg[pinmux_pkg::PF6_FUNC_LSB +: 2];
  assign pf5_code = pf_sel_reg[pinmux_pkg::PF5_FUNC_LSB +: 2];
  assign pf4_code = pf_sel_reg[pinmux_pkg::PF4_FUNC_LSB +: 2];

  // reserved code falls through to generic i/o so a stray write cannot
  // leave a pin driven by nobody
  always_comb begin
    case (pf7_code)
      pinmux_pkg::FUNC_ALT:   pf_role[7] = pinmux_pkg::PIN_DMA_REQ;
      pinmux_pkg::FUNC_PULSE: pf_role[7] = pinmux_pkg::PIN_PULSE;
      default:                pf_role[7] = pinmux_pkg::PIN_GPIO;
    endcase
  end

  always_comb begin
    case (pf6_code)
      pinmux_pkg::FUNC_ALT: begin
        if (expanded_mode) begin
          pf_role[6] = pinmux_pkg::PIN_DMA_ACK;
        end else begin
          pf_role[6] = pinmux_pkg::PIN_GPIO;
        end
      end
      pinmux_pkg::FUNC_PULSE: pf_role[6] = pinmux_pkg::PIN_PULSE;
      default:                pf_role[6] = pinmux_pkg::PIN_GPIO;
    endcase
  end

  always_comb begin
    case (pf5_code)
      pinmux_pkg::FUNC_ALT:   pf_role[5] = pinmux_pkg::PIN_DMA_REQ;
      pinmux_pkg::FUNC_PULSE: pf_role[5] = pinmux_pkg::PIN_PULSE;
      default:                pf_role[5] = pinmux_pkg::PIN_GPIO;
    endcase
  end

  always_comb begin
    case (pf4_code)
      pinmux_pkg::FUNC_ALT: begin
        if (expanded_mode) begin
          pf_role[4] = pinmux_pkg::PIN_DMA_ACK;
        end else begin
          pf_role[4] = pinmux_pkg::PIN_GPIO;
        end
      end
      pinmux_pkg::FUNC_PULSE: pf_role[4] = pinmux_pkg::PIN_PULSE;
      default:                pf_role[4] = pinmux_pkg::PIN_GPIO;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq_pins
      always_comb begin
        if (pf_sel_reg[pinmux_pkg::PF0_FUNC_BIT + gi * pinmux_pkg::PF_SINGLE_STRIDE]) begin
          pf_role[gi] = pinmux_pkg::PIN_IRQ;
        end else begin
          pf_role[gi] = pinmux_pkg::PIN_GPIO;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // port f alternate output sources
  // pulse index runs pin minus four; ack index runs down from pin 6
  logic [PF_PINS-1:0] pf_alt_out;

  always_comb begin
    pf_alt_out = '0;
    pf_alt_out[7] = pulse_out[3];
    pf_alt_out[5] = pulse_out[1];
    if (pf_role[6] == pinmux_pkg::PIN_DMA_ACK) begin
      pf_alt_out[6] = dma_acknowledge[0];
    end else begin
      pf_alt_out[6] = pulse_out[2];
    end
    if (pf_role[4] == pinmux_pkg::PIN_DMA_ACK) begin
      pf_alt_out[4] = dma_acknowledge[1];
    end else begin
      pf_alt_out[4] = pulse_out[0];
    end
  end

  // ==========================================================================
  // port f pin drive, registered so pin outputs come straight from flops
  logic [PF_PINS-1:0] pf_out_next;
  logic [PF_PINS-1:0] pf_oe_next;
  logic [PF_PINS-1:0] pf_gpio_next;

  generate
    for (gi = 0; gi < PF_PINS; gi++) begin : g_pf_drive
      always_comb begin
        case (pf_role[gi])
          pinmux_pkg::PIN_GPIO: begin
            pf_out_next[gi]  = pf_gpio_out[gi];
            pf_oe_next[gi]   = pf_gpio_oe[gi];
            pf_gpio_next[gi] = 1'b1;
          end
          pinmux_pkg::PIN_DMA_ACK,
          pinmux_pkg::PIN_PULSE: begin
            pf_out_next[gi]  = pf_alt_out[gi];
            pf_oe_next[gi]   = 1'b1;
            pf_gpio_next[gi] = 1'b0;
          end
          default: begin
            // inputs to on-chip units: the pad is released
            pf_out_next[gi]  = 1'b0;
            pf_oe_next[gi]   = 1'b0;
            pf_gpio_next[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pf_pin_out     <= '0;
      pf_pin_oe      <= '0;
      pf_pin_is_gpio <= '1;
    end else begin
      pf_pin_out     <= pf_out_next;
      pf_pin_oe      <= pf_oe_next;
      pf_pin_is_gpio <= pf_gpio_next;
    end
  end

  // the port f data logic sees the pin level one cycle late, through a flop, whatever the function
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pf_gpio_in <= '0;
    end else begin
      pf_gpio_in <= pf_pin_in;
    end
  end

  // ==========================================================================
  // port f inputs toward the dma and interrupt units
  // an unselected input is held at its idle level so a unit never sees a
  // spurious request from a pin doing something else
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dma_request <= {2{PERIPH_IDLE}};
    end else begin
      dma_request[0] <= (pf_role[7] == pinmux_pkg::PIN_DMA_REQ)
                      ? pf_pin_in[7] : PERIPH_IDLE;
      dma_request[1] <= (pf_role[5] == pinmux_pkg::PIN_DMA_REQ)
                      ? pf_pin_in[5] : PERIPH_IDLE;
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq_route
      always_ff @(posedge clock) begin
        if (!rstn) begin
          ext_interrupt_request[gi] <= PERIPH_IDLE;
        end else if (pf_role[gi] == pinmux_pkg::PIN_IRQ) begin
          ext_interrupt_request[gi] <= pf_pin_in[gi];
        end else begin
          ext_interrupt_request[gi] <= PERIPH_IDLE;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // port g pin cells
  logic [PG_PINS-1:0]     pg_read_bits;
  pinmux_pkg::pin_drive_s pg_drive [PG_PINS];

  generate
    for (gi = 0; gi < PG_PINS; gi++) begin : g_pg_cell
      pg_pin_cell u_cell (
        .dir         (pg_dir_reg[gi]),
        .func_active (pg_func_active[gi]),
        .data_q      (pg_data_reg[gi]),
        .pin_in      (pg_pin_in[gi]),
        .read_bit    (pg_read_bits[gi]),
        .drive       (pg_drive[gi])
      );

      always_ff @(posedge clock) begin
        if (!rstn) begin
          pg_pin_out[gi] <= 1'b0;
          pg_pin_oe[gi]  <= 1'b0;
        end else begin
          pg_pin_out[gi] <= pg_drive[gi].out;
          pg_pin_oe[gi]  <= pg_drive[gi].oe;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // effective role status: one bit per port f pin, set while it is generic i/o
  // taken from the next-state decode, so a read right after a mode change
  // already shows the new role; the same decode feeds the pin flops anyway
  logic [pinmux_pkg::DATA_W-1:0] pf_role_status;

  assign pf_role_status = {{(pinmux_pkg::DATA_W-PF_PINS){1'b0}}, pf_gpio_next};

  // ==========================================================================
  // read path, data one cycle after the strobe
  always_comb begin
    rdata_next = pinmux_pkg::RD_UNMAPPED;
    case (reg_req.addr)
      pinmux_pkg::OFS_PF_LOW_SEL:   rdata_next = pf_sel_reg;
      pinmux_pkg::OFS_PG_DATA:      rdata_next = pg_read_bits;
      pinmux_pkg::OFS_PG_DIR:       rdata_next = pg_dir_reg;
      pinmux_pkg::OFS_PF_ROLE_STAT: rdata_next = pf_role_status;
      default:                      rdata_next = pinmux_pkg::RD_UNMAPPED;
    endcase
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (reg_req.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// ### tb/pin_world.sv
// pads and peripheral units around the pin function block
// assumes the bench chooses the level an undriven pad is pulled to
`timescale 1ns/1ps

module pin_world (
  input  wire logic        clock,
  input  wire logic [7:0]  pf_pin_out,
  input  wire logic [7:0]  pf_pin_oe,
  input  wire logic [15:0] pg_pin_out,
  input  wire logic [15:0] pg_pin_oe,
  input  wire logic [7:0]  pf_pull,
  input  wire logic [15:0] pg_pull,
  output      logic [7:0]  pf_pin_in,
  output      logic [15:0] pg_pin_in,
  output      logic [3:0]  pulse_out,
  output      logic [1:0]  dma_acknowledge
);
  logic [5:0] pattern_reg = 6'h00;

  // ==========
  // pulse lines change every cycle, the ack pair every three or four cycles, so a stale route cannot hide
  always @(posedge clock) pattern_reg <= pattern_reg + 6'h05;
  assign pulse_out       = pattern_reg[3:0];
  assign dma_acknowledge = pattern_reg[5:4];

  // ==========
  // a pad nobody drives settles to its pull level
  assign pf_pin_in = (pf_pin_out & pf_pin_oe) | (pf_pull & ~pf_pin_oe);
  assign pg_pin_in = (pg_pin_out & pg_pin_oe) | (pg_pull & ~pg_pin_oe);
endmodule

// ### tb/pinmux_checker_assertions.sv
// concurrent checks on the pin function block, top-level ports only
// assumes one clock, sync active-low reset, one-cycle read latency
`timescale 1ns/1ps

module pinmux_checker #(
  parameter int PF_PINS = 8,
  parameter int PG_PINS = 16
) (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire pinmux_pkg::reg_req_s reg_req,
  input wire logic [15:0]          reg_rdata,
  input wire logic                 expanded_mode,
  input wire logic [PF_PINS-1:0]   pf_pin_in,
  input wire logic [PF_PINS-1:0]   pf_pin_out,
  input wire logic [PF_PINS-1:0]   pf_pin_oe,
  input wire logic [PF_PINS-1:0]   pf_pin_is_gpio,
  input wire logic [1:0]           dma_request,
  input wire logic [1:0]           dma_acknowledge,
  input wire logic [3:0]           pulse_out,
  input wire logic [3:0]           ext_interrupt_request,
  input wire logic [PG_PINS-1:0]   pg_pin_in,
  input wire logic [PG_PINS-1:0]   pg_pin_out,
  input wire logic [PG_PINS-1:0]   pg_pin_oe,
  input wire logic [PG_PINS-1:0]   pg_func_active,
  input wire logic [PG_PINS-1:0]   port_g_direction
);
  // ==========
  // register mirrors, kept from the bus writes alone
  logic [15:0] sel_q;
  logic [15:0] pgd_q;
  logic [15:0] pgdir_q;
  logic [7:0]  gpio_exp;
  logic [3:0]  irq_exp;
  logic [1:0]  dreq_exp;

  always_ff @(posedge clock) begin
    if (!rstn) sel_q <= pinmux_pkg::PF_LOW_SEL_RESET;
    else if (reg_req.wr && reg_req.addr == pinmux_pkg::OFS_PF_LOW_SEL)
      sel_q <= (reg_req.wdata & pinmux_pkg::PF_LOW_SEL_WMASK) | pinmux_pkg::PF_LOW_SEL_RESET;
  end

  always_ff @(posedge clock) begin
    if (!rstn) pgd_q <= 16'h0000;
    else if (reg_req.wr && reg_req.addr == pinmux_pkg::OFS_PG_DATA) pgd_q <= reg_req.wdata;
  end

  // direction kept apart from the design's own output so that output can be judged
  always_ff @(posedge clock) begin
    if (!rstn) pgdir_q <= 16'h0000;
    else if (reg_req.wr && reg_req.addr == pinmux_pkg::OFS_PG_DIR) pgdir_q <= reg_req.wdata;
  end

  // codes 00 and 11 are generic; 01 on the ack pins is generic in single-chip
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      gpio_exp[n] = !sel_q[2*n];
      irq_exp[n]  = sel_q[2*n] ? pf_pin_in[n] : 1'b1;
    end
    for (int n = 4; n < 8; n++)
      gpio_exp[n] = (sel_q[2*n+1] == sel_q[2*n])
        || (n % 2 == 0 && sel_q[2*n+:2] == 2'h1 && !expanded_mode);
    dreq_exp[0] = sel_q[15:14] == 2'h1 ? pf_pin_in[7] : 1'b1;
    dreq_exp[1] = sel_q[11:10] == 2'h1 ? pf_pin_in[5] : 1'b1;
  end

  // ==========
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  reset_idle_a: assert property (!$past(rstn) |-> pf_pin_oe == '0 && pf_pin_is_gpio == '1)
    else $error("port f outputs not idle after reset");
  role_gpio_a: assert property ($past(rstn) |-> pf_pin_is_gpio == $past(gpio_exp))
    else $error("port f generic flags wrong");
  pulse_route_a: assert property ($past(rstn) && $past(sel_q[15:14]) == 2'h2
    |-> pf_pin_oe[7] && pf_pin_out[7] == $past(pulse_out[3]))
    else $error("pin f7 pulse route wrong");
  dack_route_a: assert property ($past(rstn) && $past(expanded_mode)
    && $past(sel_q[13:12]) == 2'h1 |-> pf_pin_oe[6] && pf_pin_out[6] == $past(dma_acknowledge[0]))
    else $error("pin f6 ack route wrong");
  dma_req_a: assert property ($past(rstn) |-> dma_request == $past(dreq_exp))
    else $error("dma request route wrong");
  irq_route_a: assert property ($past(rstn) |-> ext_interrupt_request == $past(irq_exp))
    else $error("interrupt request route wrong");
  pg_drive_a: assert property ($past(rstn)
    |-> pg_pin_oe == $past(pgdir_q & ~pg_func_active)
    && (pg_pin_out & pg_pin_oe) == ($past(pgd_q) & pg_pin_oe))
    else $error("port g drive wrong");
  pg_read_a: assert property ($past(rstn) && $past(reg_req.rd)
    && $past(reg_req.addr) == pinmux_pkg::OFS_PG_DATA
    |-> reg_rdata == $past(pgd_q & pgdir_q | pg_pin_in & ~pgdir_q))
    else $error("port g read value wrong");
  dir_mirror_a: assert property (port_g_direction == pgdir_q)
    else $error("port g direction output wrong");
  pin4_pulse_a: assert property ($past(rstn) && $past(sel_q[9:8]) == 2'h2
    |-> pf_pin_oe[4] && pf_pin_out[4] == $past(pulse_out[0]))
    else $error("pin f4 pulse route wrong");
  sel_read_a: assert property ($past(rstn) && $past(reg_req.rd)
    && $past(reg_req.addr) == pinmux_pkg::OFS_PF_LOW_SEL |-> reg_rdata == $past(sel_q))
    else $error("function select read wrong");
  rdata_idle_a: assert property ($past(rstn) && !$past(reg_req.rd) |-> reg_rdata == '0)
    else $error("read data not idle");

  pulse_c: cover property (pf_pin_oe[7] && !pf_pin_is_gpio[7]);
  dack_c: cover property (expanded_mode && sel_q[13:12] == 2'h1);
  pg_read_c: cover property (reg_req.rd && reg_req.addr == pinmux_pkg::OFS_PG_DATA);
endmodule

bind port_pin_function_select pinmux_checker #(.PF_PINS(PF_PINS), .PG_PINS(PG_PINS)) chk_u (
  .clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .expanded_mode(expanded_mode), .pf_pin_in(pf_pin_in), .pf_pin_out(pf_pin_out),
  .pf_pin_oe(pf_pin_oe), .pf_pin_is_gpio(pf_pin_is_gpio), .dma_request(dma_request),
  .dma_acknowledge(dma_acknowledge), .pulse_out(pulse_out),
  .ext_interrupt_request(ext_interrupt_request), .pg_pin_in(pg_pin_in),
  .pg_pin_out(pg_pin_out), .pg_pin_oe(pg_pin_oe), .pg_func_active(pg_func_active),
  .port_g_direction(port_g_direction)
);

// ### tb/tb_top.sv
// self-checking bench for the pin function block
// assumes the pad model beside the design and the bound checker
`timescale 1ns/1ps

module tb_top;
  logic                 clock         = 1'b0;
  logic                 rstn          = 1'b0;
  pinmux_pkg::reg_req_s req           = '0;
  logic                 expanded_mode = 1'b0;
  logic [7:0]           pf_gpio_out   = 8'hC3;
  logic [7:0]           pf_gpio_oe    = 8'h00;
  logic [15:0]          pg_func       = 16'h0000;
  logic [15:0]          rdata;
  logic [7:0]           pf_pin_in;
  logic [7:0]           pf_pin_out;
  logic [7:0]           pf_pin_oe;
  logic [7:0]           pf_gpio_in;
  logic [7:0]           is_gpio;
  logic [1:0]           dma_request;
  logic [1:0]           dma_ack;
  logic [3:0]           pulse;
  logic [3:0]           ext_irq;
  logic [15:0]          pg_pin_in;
  logic [15:0]          pg_pin_out;
  logic [15:0]          pg_pin_oe;
  logic [1:0]           code;
  logic                 gp;
  logic                 ak;
  int                   err_count     = 0;
  int                   checked       = 0;

  always #5 clock = ~clock;

  port_pin_function_select dut_u (
    .clock(clock), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
    .expanded_mode(expanded_mode), .pf_pin_in(pf_pin_in), .pf_pin_out(pf_pin_out),
    .pf_pin_oe(pf_pin_oe), .pf_gpio_out(pf_gpio_out), .pf_gpio_oe(pf_gpio_oe),
    .pf_gpio_in(pf_gpio_in), .pf_pin_is_gpio(is_gpio), .dma_request(dma_request),
    .dma_acknowledge(dma_ack), .pulse_out(pulse), .ext_interrupt_request(ext_irq),
    .pg_pin_in(pg_pin_in), .pg_pin_out(pg_pin_out), .pg_pin_oe(pg_pin_oe),
    .pg_func_active(pg_func), .port_g_direction()
  );

  pin_world pads_u (
    .clock(clock), .pf_pin_out(pf_pin_out), .pf_pin_oe(pf_pin_oe),
    .pg_pin_out(pg_pin_out), .pg_pin_oe(pg_pin_oe), .pf_pull(8'h5A),
    .pg_pull(16'hA5A5), .pf_pin_in(pf_pin_in), .pg_pin_in(pg_pin_in),
    .pulse_out(pulse), .dma_acknowledge(dma_ack)
  );

  // ==========
  // bus tasks and comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    check({16'h0000, rdata}, {16'h0000, e});
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========
  // tests
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd_chk(pinmux_pkg::OFS_PF_LOW_SEL, 16'h00AA);
    rd_chk(pinmux_pkg::OFS_PG_DATA, 16'hA5A5);
    rd_chk(pinmux_pkg::OFS_PG_DIR, 16'h0000);
    rd_chk(8'h02, 16'h0000);
    check({24'h0, is_gpio}, 32'h0000_00FF);
    wr_reg(pinmux_pkg::OFS_PG_DIR, 16'hFFFF);
    rd_chk(pinmux_pkg::OFS_PG_DATA, 16'h0000);
    $display("test reset done");

    // every code of every field in both chip modes
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      expanded_mode <= m[0];
      for (int c = 0; c < 4; c++) begin
        code = c[1:0];
        gp   = code == 2'h0 || code == 2'h3;
        ak   = gp || (code == 2'h1 && m == 0);
        wr_reg(pinmux_pkg::OFS_PF_LOW_SEL, {code, code, code, code, code[0] ? 8'h55 : 8'h00});
        rd_chk(pinmux_pkg::OFS_PF_LOW_SEL, {code, code, code, code, code[0] ? 8'hFF : 8'hAA});
        rd_chk(pinmux_pkg::OFS_PF_ROLE_STAT, {8'h00, gp, ak, gp, ak, {4{!code[0]}}});
        check({is_gpio, pf_pin_oe[7:4]}, {gp, ak, gp, ak, {4{!code[0]}},
          code == 2'h2 ? 4'hF : (code == 2'h1 && m == 1) ? 4'h5 : 4'h0});
        check({dma_request, ext_irq}, {code == 2'h1 ? 2'h0 : 2'h3,
          code[0] ? 4'hA : 4'hF});
      end
    end
    @(posedge clock);
    pf_gpio_oe <= 8'hFF;
    wr_reg(pinmux_pkg::OFS_PF_LOW_SEL, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check({pf_pin_oe, pf_pin_out, pf_gpio_in}, 24'hFF_C3C3);
    $display("test port f done");

    // port g read and drive for each direction and function mix
    @(posedge clock);
    pf_gpio_oe <= 8'h00;
    pg_func <= 16'hF000;
    wr_reg(pinmux_pkg::OFS_PG_DIR, 16'hFF00);
    wr_reg(pinmux_pkg::OFS_PG_DATA, 16'h1234);
    rd_chk(pinmux_pkg::OFS_PG_DATA, 16'h12A5);
    check({pg_pin_oe, pg_pin_out & pg_pin_oe}, 32'h0F00_0200);
    rd_chk(pinmux_pkg::OFS_PG_DIR, 16'hFF00);
    wr_reg(pinmux_pkg::OFS_PG_DIR, 16'h0000);
    wr_reg(pinmux_pkg::OFS_PG_DATA, 16'hBEEF);
    rd_chk(pinmux_pkg::OFS_PG_DATA, 16'hA5A5);
    check({16'h0000, pg_pin_oe}, 32'h0000_0000);
    wr_reg(pinmux_pkg::OFS_PG_DIR, 16'hFFFF);
    rd_chk(pinmux_pkg::OFS_PG_DATA, 16'hBEEF);
    check({16'h0000, pg_pin_out & pg_pin_oe}, 32'h0000_0EEF);
    $display("test port g done");
    wrap_up;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
